// ### verilog/bfls_pkg.sv
// Contract
// (RULE1) rotate/arith shift right, flags Z C N V
// (RULE2) nibble swap, flags untouched
// (RULE3) register bit copied into transfer flag
// (RULE4) transfer flag written into register bit
// (RULE5) status bit set/clear, dedicated flag ops
// (RULE6) overflow flag forced one or zero
// (RULE7) half-carry flag forced one or zero
// (RULE8) copy, pair copy, immediate: one cycle
// (RULE9) indirect load, optional post-increment, two cycles
// (RULE10) pre-decrement pointer then load
// (RULE11) load at Y or Z plus displacement
// (RULE12) direct load from address constant
// (RULE13) indirect store, optional post-increment
// (RULE14) pre-decrement pointer then store
// (RULE15) store at pointer plus displacement
`default_nettype none
package bfls_pkg;

  // clock rate of clk_sys
  localparam int unsigned CLK_HZ = 20_000_000;

  // register byte offsets on the avalon slave
  localparam logic [4:0] OFS_CMD   = 5'h00;
  localparam logic [4:0] OFS_DADDR = 5'h04;
  localparam logic [4:0] OFS_STAT  = 5'h08;
  localparam logic [4:0] OFS_RSEL  = 5'h0c;
  localparam logic [4:0] OFS_RDATA = 5'h10;
  localparam logic [4:0] OFS_INFO  = 5'h14;

  // command word field positions
  localparam int OP_LSB   = 0;
  localparam int PTR_LSB  = 6;
  localparam int RD_LSB   = 8;
  localparam int MODE_LSB = 13;
  localparam int RR_LSB   = 16;
  localparam int IMM_LSB  = 24;

  // status_register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // reset values
  localparam logic [7:0]  STAT_RST  = 8'h00;
  localparam logic [31:0] CMD_RST   = 32'h0000_0000;
  localparam logic [15:0] DADDR_RST = 16'h0000;
  localparam logic [4:0]  RSEL_RST  = 5'h00;

  // pointer pairs: x, y, z sit in registers 26..31
  localparam logic [1:0] PTR_X = 2'h0;
  localparam logic [1:0] PTR_Y = 2'h1;
  localparam logic [1:0] PTR_Z = 2'h2;
  localparam logic [3:0] PTR_PAIR_BASE = 4'hd;

  // addressing modes of indirect transfers
  localparam logic [1:0] MODE_PLAIN = 2'h0;
  localparam logic [1:0] MODE_POSTINC = 2'h1;
  localparam logic [1:0] MODE_PREDEC = 2'h2;

  // operation codes
  localparam logic [5:0] NOP_OP                    = 6'h00;
  localparam logic [5:0] ROTATE_RIGHT_CARRY_OP     = 6'h01;
  localparam logic [5:0] ARITH_SHIFT_RIGHT_OP      = 6'h02;
  localparam logic [5:0] NIBBLE_SWAP_OP            = 6'h03;
  localparam logic [5:0] STATUS_BIT_SET_OP         = 6'h04;
  localparam logic [5:0] STATUS_BIT_CLEAR_OP       = 6'h05;
  localparam logic [5:0] REG_BIT_TO_TRANSFER_FLAG_OP = 6'h06;
  localparam logic [5:0] TRANSFER_FLAG_TO_REG_BIT_OP = 6'h07;
  localparam logic [5:0] SET_CARRY_OP              = 6'h08;
  localparam logic [5:0] CLEAR_CARRY_OP            = 6'h09;
  localparam logic [5:0] SET_NEGATIVE_OP           = 6'h0a;
  localparam logic [5:0] CLEAR_NEGATIVE_OP         = 6'h0b;
  localparam logic [5:0] SET_ZERO_OP               = 6'h0c;
  localparam logic [5:0] CLEAR_ZERO_OP             = 6'h0d;
  localparam logic [5:0] GLOBAL_IRQ_ON_OP          = 6'h0e;
  localparam logic [5:0] GLOBAL_IRQ_OFF_OP         = 6'h0f;
  localparam logic [5:0] SET_SIGN_OP               = 6'h10;
  localparam logic [5:0] CLEAR_SIGN_OP             = 6'h11;
  localparam logic [5:0] SET_OVERFLOW_OP           = 6'h12;
  localparam logic [5:0] CLEAR_OVERFLOW_OP         = 6'h13;
  localparam logic [5:0] SET_TRANSFER_FLAG_OP      = 6'h14;
  localparam logic [5:0] CLEAR_TRANSFER_FLAG_OP    = 6'h15;
  localparam logic [5:0] SET_HALFCARRY_OP          = 6'h16;
  localparam logic [5:0] CLEAR_HALFCARRY_OP        = 6'h17;
  localparam logic [5:0] REGISTER_COPY_OP          = 6'h18;
  localparam logic [5:0] REGISTER_PAIR_COPY_OP     = 6'h19;
  localparam logic [5:0] LOAD_IMMEDIATE_OP         = 6'h1a;
  localparam logic [5:0] INDIRECT_LOAD_OP          = 6'h1b;
  localparam logic [5:0] DISPLACED_LOAD_OP         = 6'h1c;
  localparam logic [5:0] DIRECT_LOAD_OP            = 6'h1d;
  localparam logic [5:0] INDIRECT_WRITE_OP         = 6'h1e;
  localparam logic [5:0] DISPLACED_WRITE_OP        = 6'h1f;

  // execution sequencer states
  typedef enum logic [1:0] {
    SQ_IDLE,
    SQ_EX1,
    SQ_EX2
  } bfls_state_e;

endpackage
`default_nettype wire

// ### verilog/bfls_shift_unit.sv
`default_nettype none
// right shift through carry or sign, with its flags
module bfls_shift_unit (
  input  wire logic [7:0] val,
  input  wire logic       carry_in,
  input  wire logic       arith,
  output logic [7:0]      res,
  output logic            c_out,
  output logic            z_out,
  output logic            n_out,
  output logic            v_out
);

  // old carry or the sign enters at the top
  always_comb begin
    res   = {(arith ? val[7] : carry_in), val[7:1]}; // RULE1
    c_out = val[0]; // RULE1
    n_out = res[7];
    z_out = (res == 8'h00);
    v_out = res[7] ^ val[0]; // overflow is n xor c after the shift
  end

endmodule
`default_nettype wire

// ### verilog/bfls_core.sv
`default_nettype none
module bfls_core
  import bfls_pkg::*;
#(
  parameter int unsigned DMEM_DEPTH = 256
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [7:0]       status_flags,
  output logic             busy
);

  localparam int AW = $clog2(DMEM_DEPTH);

  // byte-lane merge of a bus write onto the current value
  function automatic logic [31:0] be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  be
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // operations that go through the data memory
  function automatic logic op_is_load(input logic [5:0] op);
    return (op == INDIRECT_LOAD_OP) || (op == DISPLACED_LOAD_OP) ||
           (op == DIRECT_LOAD_OP);
  endfunction

  function automatic logic op_is_store(input logic [5:0] op);
    return (op == INDIRECT_WRITE_OP) || (op == DISPLACED_WRITE_OP);
  endfunction

  // register file and data memory
  logic [7:0] rf [32];
  logic [7:0] dmem [DMEM_DEPTH];

  // control state
  bfls_state_e state_r;
  bfls_state_e state_nxt;
  logic [31:0] cmd_r;
  logic [31:0] cmd_nxt;
  logic [15:0] daddr_r;
  logic [15:0] daddr_nxt;
  logic [7:0]  stat_r;
  logic [7:0]  stat_nxt;
  logic [4:0]  rsel_r;
  logic [4:0]  rsel_nxt;
  logic        err_r;
  logic        err_nxt;
  logic [15:0] addr_r;
  logic [15:0] addr_nxt;
  logic        wait_r;
  logic        wait_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        busy_r;
  logic        busy_nxt;

  // write ports of the register file and memory
  logic        bw_en;
  logic [4:0]  bw_idx;
  logic [7:0]  bw_data;
  logic        pw_en;
  logic [3:0]  pw_idx;
  logic [15:0] pw_data;
  logic        mw_en;
  logic [7:0]  mw_data;

  // command fields
  logic [5:0]  op;
  logic [1:0]  ptr;
  logic [4:0]  rd;
  logic [1:0]  mode;
  logic [4:0]  rr;
  logic [7:0]  imm;
  logic [3:0]  ptr_pair;
  logic [15:0] ptr_val;
  logic [15:0] disp;
  logic [7:0]  rd_val;
  logic [7:0]  rr_val;

  // bus-side views
  logic [4:0]  bus_ofs;
  logic [31:0] bus_cur;
  logic [31:0] bus_wm;

  // shift unit results
  logic [7:0] sh_res;
  logic       sh_c;
  logic       sh_z;
  logic       sh_n;
  logic       sh_v;

  // field decode of the latched command
  assign op       = cmd_r[OP_LSB +: 6];
  assign ptr      = cmd_r[PTR_LSB +: 2];
  assign rd       = cmd_r[RD_LSB +: 5];
  assign mode     = cmd_r[MODE_LSB +: 2];
  assign rr       = cmd_r[RR_LSB +: 5];
  assign imm      = cmd_r[IMM_LSB +: 8];
  assign ptr_pair = PTR_PAIR_BASE + {2'h0, ptr};
  assign ptr_val  = {rf[{ptr_pair, 1'b1}], rf[{ptr_pair, 1'b0}]};
  assign disp     = {10'h000, imm[5:0]}; // displacement is unsigned
  assign rd_val   = rf[rd];
  assign rr_val   = rf[rr];

  bfls_shift_unit u_shift (
    .val      (rd_val),
    .carry_in (stat_r[FLAG_C]),
    .arith    (op == ARITH_SHIFT_RIGHT_OP),
    .res      (sh_res),
    .c_out    (sh_c),
    .z_out    (sh_z),
    .n_out    (sh_n),
    .v_out    (sh_v)
  );

  // current value of the addressed register, zero when unmapped
  always_comb begin
    bus_ofs = {avs_address, 2'b00};
    unique case (bus_ofs)
      OFS_CMD:   bus_cur = cmd_r;
      OFS_DADDR: bus_cur = {16'h0000, daddr_r};
      OFS_STAT:  bus_cur = {24'h000000, stat_r};
      OFS_RSEL:  bus_cur = {27'h0000000, rsel_r};
      OFS_RDATA: bus_cur = {24'h000000, rf[rsel_r]};
      OFS_INFO:  bus_cur = {31'h00000000, err_r};
      default:   bus_cur = 32'h0000_0000;
    endcase
    bus_wm = be_merge(bus_cur, avs_writedata, avs_byteenable);
  end

  // sequencer, bus slave and execution
  always_comb begin
    state_nxt = state_r;
    cmd_nxt   = cmd_r;
    daddr_nxt = daddr_r;
    stat_nxt  = stat_r;
    rsel_nxt  = rsel_r;
    err_nxt   = err_r;
    addr_nxt  = addr_r;
    wait_nxt  = 1'b1;
    rdata_nxt = rdata_r;
    bw_en     = 1'b0;
    bw_idx    = rd;
    bw_data   = 8'h00;
    pw_en     = 1'b0;
    pw_idx    = ptr_pair;
    pw_data   = 16'h0000;
    mw_en     = 1'b0;
    mw_data   = rr_val;
    unique case (state_r)
      // bus accesses are only taken while no command runs
      SQ_IDLE: begin
        if ((avs_read || avs_write) && wait_r) begin
          wait_nxt = 1'b0;
          if (avs_read) begin
            rdata_nxt = bus_cur;
          end else begin
            unique case (bus_ofs)
              OFS_CMD: begin
                cmd_nxt   = bus_wm;
                err_nxt   = 1'b0;
                state_nxt = SQ_EX1;
              end
              OFS_DADDR: daddr_nxt = bus_wm[15:0];
              OFS_STAT:  stat_nxt = bus_wm[7:0];
              OFS_RSEL:  rsel_nxt = bus_wm[4:0];
              OFS_RDATA: begin
                bw_en   = 1'b1;
                bw_idx  = rsel_r;
                bw_data = bus_wm[7:0];
              end
              default: ; // read-only or unmapped: ignored
            endcase
          end
        end
      end
      // single-cycle ops finish here; memory ops form the address
      SQ_EX1: begin
        state_nxt = SQ_IDLE;
        unique case (op)
          NOP_OP: ;
          ROTATE_RIGHT_CARRY_OP, ARITH_SHIFT_RIGHT_OP: begin
            bw_en            = 1'b1; // RULE1
            bw_data          = sh_res;
            stat_nxt[FLAG_C] = sh_c;
            stat_nxt[FLAG_Z] = sh_z;
            stat_nxt[FLAG_N] = sh_n;
            stat_nxt[FLAG_V] = sh_v;
          end
          NIBBLE_SWAP_OP: begin
            bw_en   = 1'b1; // RULE2
            bw_data = {rd_val[3:0], rd_val[7:4]};
          end
          STATUS_BIT_SET_OP:   stat_nxt[imm[2:0]] = 1'b1; // RULE5
          STATUS_BIT_CLEAR_OP: stat_nxt[imm[2:0]] = 1'b0; // RULE5
          REG_BIT_TO_TRANSFER_FLAG_OP: stat_nxt[FLAG_T] = rr_val[imm[2:0]]; // RULE3
          TRANSFER_FLAG_TO_REG_BIT_OP: begin
            bw_en             = 1'b1; // RULE4
            bw_data           = rd_val;
            bw_data[imm[2:0]] = stat_r[FLAG_T];
          end
          SET_CARRY_OP:           stat_nxt[FLAG_C] = 1'b1; // RULE5
          CLEAR_CARRY_OP:         stat_nxt[FLAG_C] = 1'b0; // RULE5
          SET_NEGATIVE_OP:        stat_nxt[FLAG_N] = 1'b1; // RULE5
          CLEAR_NEGATIVE_OP:      stat_nxt[FLAG_N] = 1'b0; // RULE5
          SET_ZERO_OP:            stat_nxt[FLAG_Z] = 1'b1; // RULE5
          CLEAR_ZERO_OP:          stat_nxt[FLAG_Z] = 1'b0; // RULE5
          GLOBAL_IRQ_ON_OP:       stat_nxt[FLAG_I] = 1'b1; // RULE5
          GLOBAL_IRQ_OFF_OP:      stat_nxt[FLAG_I] = 1'b0; // RULE5
          SET_SIGN_OP:            stat_nxt[FLAG_S] = 1'b1; // RULE5
          CLEAR_SIGN_OP:          stat_nxt[FLAG_S] = 1'b0; // RULE5
          SET_TRANSFER_FLAG_OP:   stat_nxt[FLAG_T] = 1'b1; // RULE5
          CLEAR_TRANSFER_FLAG_OP: stat_nxt[FLAG_T] = 1'b0; // RULE5
          SET_OVERFLOW_OP:        stat_nxt[FLAG_V] = 1'b1; // RULE6
          CLEAR_OVERFLOW_OP:      stat_nxt[FLAG_V] = 1'b0; // RULE6
          SET_HALFCARRY_OP:       stat_nxt[FLAG_H] = 1'b1; // RULE7
          CLEAR_HALFCARRY_OP:     stat_nxt[FLAG_H] = 1'b0; // RULE7
          REGISTER_COPY_OP: begin
            bw_en   = 1'b1; // RULE8
            bw_data = rr_val;
          end
          REGISTER_PAIR_COPY_OP: begin
            // low index bits ignored: pairs are always even-aligned
            pw_en   = 1'b1; // RULE8
            pw_idx  = rd[4:1];
            pw_data = {rf[{rr[4:1], 1'b1}], rf[{rr[4:1], 1'b0}]};
          end
          LOAD_IMMEDIATE_OP: begin
            bw_en   = 1'b1; // RULE8
            bw_data = imm;
          end
          INDIRECT_LOAD_OP, INDIRECT_WRITE_OP: begin
            state_nxt = SQ_EX2;
            unique case (mode)
              MODE_PLAIN: addr_nxt = ptr_val; // RULE9 RULE13
              MODE_POSTINC: begin
                // pointer bumps now; the access uses the latched old value
                addr_nxt = ptr_val; // RULE9 RULE13
                pw_en    = 1'b1;
                pw_data  = ptr_val + 16'h0001;
              end
              MODE_PREDEC: begin
                addr_nxt = ptr_val - 16'h0001; // RULE10 RULE14
                pw_en    = 1'b1;
                pw_data  = ptr_val - 16'h0001;
              end
              default: begin
                err_nxt   = 1'b1;
                state_nxt = SQ_IDLE;
              end
            endcase
            if (ptr != PTR_X && ptr != PTR_Y && ptr != PTR_Z) begin
              pw_en     = 1'b0;
              err_nxt   = 1'b1;
              state_nxt = SQ_IDLE;
            end
          end
          DISPLACED_LOAD_OP, DISPLACED_WRITE_OP: begin
            // only y and z carry a displacement; pointer left as is
            if (ptr == PTR_Y || ptr == PTR_Z) begin
              addr_nxt  = ptr_val + disp; // RULE11 RULE15
              state_nxt = SQ_EX2;
            end else begin
              err_nxt = 1'b1;
            end
          end
          DIRECT_LOAD_OP: begin
            addr_nxt  = daddr_r; // RULE12
            state_nxt = SQ_EX2;
          end
          default: err_nxt = 1'b1; // unknown code: sets the error flag only
        endcase
      end
      // memory access of the second cycle, flags never touched
      SQ_EX2: begin
        state_nxt = SQ_IDLE;
        if (op_is_load(op)) begin
          bw_en   = 1'b1; // RULE9 RULE10 RULE11 RULE12
          bw_data = dmem[addr_r[AW-1:0]];
        end
        if (op_is_store(op)) begin
          mw_en = 1'b1; // RULE13 RULE14 RULE15
        end
      end
    endcase
    busy_nxt = (state_nxt != SQ_IDLE);
  end

  // control registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= SQ_IDLE;
      cmd_r   <= CMD_RST;
      daddr_r <= DADDR_RST;
      stat_r  <= STAT_RST;
      rsel_r  <= RSEL_RST;
      err_r   <= 1'b0;
      addr_r  <= 16'h0000;
      wait_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
      busy_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cmd_r   <= cmd_nxt;
      daddr_r <= daddr_nxt;
      stat_r  <= stat_nxt;
      rsel_r  <= rsel_nxt;
      err_r   <= err_nxt;
      addr_r  <= addr_nxt;
      wait_r  <= wait_nxt;
      rdata_r <= rdata_nxt;
      busy_r  <= busy_nxt;
    end
  end

  // storage arrays, no reset: contents are data, not control
  always_ff @(posedge clk_sys) begin
    if (pw_en) begin
      rf[{pw_idx, 1'b1}] <= pw_data[15:8];
      rf[{pw_idx, 1'b0}] <= pw_data[7:0];
    end
    if (bw_en) begin
      rf[bw_idx] <= bw_data;
    end
    if (mw_en) begin
      dmem[addr_r[AW-1:0]] <= mw_data;
    end
  end

  // outputs straight from flip-flops
  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign status_flags    = stat_r;
  assign busy            = busy_r;

endmodule
`default_nettype wire

// ### sim/bfls_core_assertions.sv
`default_nettype none
module bfls_core_assertions
  import bfls_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [2:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [7:0]  status_flags,
  input wire logic        busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // command write accepted at this edge
  logic       take;
  logic [5:0] op;
  logic       mem_ok;
  assign take = avs_write && avs_waitrequest && !busy && avs_address == 3'h0;
  assign op = avs_writedata[5:0];
  // rejected operand mixes are kept out, they may end early
  assign mem_ok = op inside {[INDIRECT_LOAD_OP:DISPLACED_WRITE_OP]} && avs_writedata[7:6] != 2'h3
    && avs_writedata[14:13] != 2'h3 && !(avs_writedata[7:6] == PTR_X
    && (op == DISPLACED_LOAD_OP || op == DISPLACED_WRITE_OP));

  a_reset_idle: assert property (disable iff (1'b0) rst |=> avs_waitrequest && !busy
    && status_flags == STAT_RST) else $error("outputs not idle after reset");
  a_answer_next: assert property ((avs_read || avs_write) && avs_waitrequest && !busy
    |=> !avs_waitrequest) else $error("accepted access not answered next cycle");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_stall_busy: assert property (busy && $past(busy) |-> avs_waitrequest)
    else $error("access answered while a command runs");
  a_single_cycle: assert property (
    take && op inside {[ROTATE_RIGHT_CARRY_OP:LOAD_IMMEDIATE_OP]} |=> busy ##1 !busy)
    else $error("single cycle op took wrong time");
  a_mem_two_cycle: assert property (
    take && mem_ok |=> busy ##1 busy ##1 !busy) else $error("memory op took wrong time");
  a_mem_flags_keep: assert property (
    take && mem_ok |=> $stable(status_flags) [*3]) else $error("memory op moved flags");
  a_set_carry: assert property (
    take && op == SET_CARRY_OP |-> ##[2:3] status_flags[FLAG_C]) else $error("carry not set");
  a_clear_overflow: assert property (
    take && op == CLEAR_OVERFLOW_OP |-> ##[2:3] !status_flags[FLAG_V])
    else $error("overflow not cleared");
  a_set_halfcarry: assert property (
    take && op == SET_HALFCARRY_OP |-> ##[2:3] status_flags[FLAG_H])
    else $error("half carry not set");
  a_readdata_hold: assert property (avs_waitrequest && $past(avs_waitrequest)
    |-> $stable(avs_readdata)) else $error("read data moved while idle");

  c_rotate: cover property (take && op == ROTATE_RIGHT_CARRY_OP);
  c_mem: cover property (take && mem_ok);
  c_read: cover property (avs_read && !avs_waitrequest);
endmodule

bind bfls_core bfls_core_assertions u_chk (.clk_sys(clk_sys), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .status_flags(status_flags), .busy(busy));
`default_nettype wire

// ### sim/bfls_host_model.sv
`default_nettype none
// bus master standing in for software
module bfls_host_model (
  input  wire logic        clk_sys,
  output logic [2:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  output logic [3:0]       avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    avs_address = 3'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
  end
  // hold the request until waitrequest is sampled low; ok drops on timeout
  task automatic access(input logic [2:0] a, input logic w, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] q, output logic ok);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    ok = (avs_waitrequest === 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= ~d; // stale data never looks valid
  endtask
endmodule
`default_nettype wire

// ### sim/bfls_core_bench.sv
`default_nettype none
module bfls_core_bench
  import bfls_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] stat;
    logic [7:0] dval;
    logic [7:0] rval;
    logic [5:0] op;
    logic [7:0] imm;
    logic [7:0] exp_d;
    logic [7:0] exp_f;
  } bfls_row_s;
  localparam logic [4:0] R_DST = 5'h10;
  localparam logic [4:0] R_SRC = 5'h11;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  status_flags;
  logic        busy;
  logic [3:0]  lanes = 4'hf;
  int          num_errors = 0;
  int          total_checks = 0;
  int          fbit[8] = '{FLAG_C, FLAG_N, FLAG_Z, FLAG_I, FLAG_S, FLAG_V, FLAG_T, FLAG_H};
  // stat, rd value, rr value, op, imm, rd expected, flags expected
  bfls_row_s   rows[13] = '{
    '{8'h73, 8'h81, 8'h00, ROTATE_RIGHT_CARRY_OP, 8'h00, 8'hc0, 8'h75},
    '{8'h01, 8'h02, 8'h00, ROTATE_RIGHT_CARRY_OP, 8'h00, 8'h81, 8'h0c},
    '{8'h00, 8'h81, 8'h00, ARITH_SHIFT_RIGHT_OP, 8'h00, 8'hc0, 8'h05},
    '{8'h00, 8'h01, 8'h00, ARITH_SHIFT_RIGHT_OP, 8'h00, 8'h00, 8'h0b},
    '{8'ha5, 8'h3c, 8'h00, NIBBLE_SWAP_OP, 8'h00, 8'hc3, 8'ha5},
    '{8'h00, 8'h55, 8'h08, REG_BIT_TO_TRANSFER_FLAG_OP, 8'h03, 8'h55, 8'h40},
    '{8'hff, 8'h55, 8'hf7, REG_BIT_TO_TRANSFER_FLAG_OP, 8'h03, 8'h55, 8'hbf},
    '{8'h40, 8'h00, 8'h00, TRANSFER_FLAG_TO_REG_BIT_OP, 8'h07, 8'h80, 8'h40},
    '{8'hbf, 8'hff, 8'h00, TRANSFER_FLAG_TO_REG_BIT_OP, 8'h00, 8'hfe, 8'hbf},
    '{8'h00, 8'h55, 8'h00, STATUS_BIT_SET_OP, 8'h07, 8'h55, 8'h80},
    '{8'hff, 8'h55, 8'h00, STATUS_BIT_CLEAR_OP, 8'h02, 8'h55, 8'hfb},
    '{8'hff, 8'h00, 8'h9a, REGISTER_COPY_OP, 8'h00, 8'h9a, 8'hff},
    '{8'h5a, 8'h00, 8'h00, LOAD_IMMEDIATE_OP, 8'he4, 8'he4, 8'h5a}};

  always #25 clk_sys = ~clk_sys;

  bfls_host_model host (.clk_sys(clk_sys), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  bfls_core #(.DMEM_DEPTH(256)) dut (.clk_sys(clk_sys), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .status_flags(status_flags), .busy(busy));

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // a stuck bus ends the run through the closing report
  task automatic bus(input logic [4:0] ofs, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    logic ok;
    host.access(ofs[4:2], w, d, lanes, q, ok);
    if (!ok) begin
      num_errors++;
      $display("BAD bus answer expected waitrequest low seen none");
      conclude();
    end
  endtask
  task automatic wr(input logic [4:0] ofs, input logic [31:0] d);
    logic [31:0] q;
    bus(ofs, 1'b1, d, q);
  endtask
  task automatic rd_chk(input string what, input logic [4:0] ofs, input logic [31:0] exp);
    logic [31:0] q;
    bus(ofs, 1'b0, 32'h0, q);
    chk(what, exp, q);
  endtask
  task automatic setreg(input logic [4:0] r, input logic [7:0] v);
    wr(OFS_RSEL, {27'h0, r});
    wr(OFS_RDATA, {24'h0, v});
  endtask
  task automatic regchk(input string what, input logic [4:0] r, input logic [7:0] v);
    wr(OFS_RSEL, {27'h0, r});
    rd_chk(what, OFS_RDATA, {24'h0, v});
  endtask
  function automatic logic [31:0] cmd(logic [5:0] op, logic [1:0] ptr, logic [4:0] rd,
                                      logic [1:0] mode, logic [4:0] rr, logic [7:0] imm);
    return {imm, 3'h0, rr, 1'b0, mode, rd, ptr, op};
  endfunction

  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    chk("flag port", 32'h0, {24'h0, status_flags});
    chk("busy", 32'h0, {31'h0, busy});
    rd_chk("stat", OFS_STAT, 32'h0);
    rd_chk("cmd", OFS_CMD, CMD_RST);
    $display("reset test done");
    // one-cycle register and flag ops from the table
    foreach (rows[i]) begin
      wr(OFS_STAT, {24'h0, rows[i].stat});
      setreg(R_DST, rows[i].dval);
      setreg(R_SRC, rows[i].rval);
      wr(OFS_CMD, cmd(rows[i].op, PTR_X, R_DST, MODE_PLAIN, R_SRC, rows[i].imm));
      rd_chk("flags", OFS_STAT, {24'h0, rows[i].exp_f});
      chk("flag port", {24'h0, rows[i].exp_f}, {24'h0, status_flags});
      regchk("rd", R_DST, rows[i].exp_d);
      $display("row %0d done", i);
    end
    // every dedicated set and clear, other flags held opposite
    foreach (fbit[i]) begin
      wr(OFS_STAT, 32'h0);
      wr(OFS_CMD, cmd(SET_CARRY_OP + 6'(2 * i), PTR_X, R_DST, MODE_PLAIN, R_SRC, 8'h0));
      rd_chk("set", OFS_STAT, {24'h0, 8'h01 << fbit[i]});
      wr(OFS_STAT, 32'hff);
      wr(OFS_CMD, cmd(SET_CARRY_OP + 6'(2 * i + 1), PTR_X, R_DST, MODE_PLAIN, R_SRC, 8'h0));
      rd_chk("clear", OFS_STAT, {24'h0, ~(8'h01 << fbit[i])});
    end
    $display("flag op test done");
    // stores then loads over pointer pairs, flags must stay put
    wr(OFS_STAT, 32'ha5);
    setreg(5'h10, 8'h11);
    setreg(5'h1c, 8'h40);
    setreg(5'h1d, 8'h00);
    wr(OFS_CMD, cmd(INDIRECT_WRITE_OP, PTR_Y, 5'h0, MODE_POSTINC, 5'h10, 8'h0));
    regchk("y post inc", 5'h1c, 8'h41);
    setreg(5'h10, 8'h22);
    setreg(5'h1c, 8'h42);
    wr(OFS_CMD, cmd(INDIRECT_WRITE_OP, PTR_Y, 5'h0, MODE_PREDEC, 5'h10, 8'h0));
    regchk("y pre dec", 5'h1c, 8'h41);
    setreg(5'h10, 8'h33);
    wr(OFS_CMD, cmd(DISPLACED_WRITE_OP, PTR_Y, 5'h0, MODE_PLAIN, 5'h10, 8'h04));
    regchk("y kept", 5'h1c, 8'h41);
    wr(OFS_DADDR, 32'h45);
    wr(OFS_CMD, cmd(DIRECT_LOAD_OP, PTR_X, 5'h14, MODE_PLAIN, 5'h0, 8'h0));
    regchk("direct", 5'h14, 8'h33);
    wr(OFS_CMD, cmd(INDIRECT_LOAD_OP, PTR_Y, 5'h15, MODE_PLAIN, 5'h0, 8'h0));
    regchk("plain load", 5'h15, 8'h22);
    setreg(5'h1a, 8'h40);
    setreg(5'h1b, 8'h00);
    wr(OFS_CMD, cmd(INDIRECT_LOAD_OP, PTR_X, 5'h16, MODE_POSTINC, 5'h0, 8'h0));
    regchk("post load", 5'h16, 8'h11);
    regchk("x post inc", 5'h1a, 8'h41);
    wr(OFS_CMD, cmd(INDIRECT_LOAD_OP, PTR_X, 5'h17, MODE_PREDEC, 5'h0, 8'h0));
    regchk("pre load", 5'h17, 8'h11);
    regchk("x pre dec", 5'h1a, 8'h40);
    setreg(5'h1e, 8'h30);
    setreg(5'h1f, 8'h00);
    wr(OFS_CMD, cmd(DISPLACED_LOAD_OP, PTR_Z, 5'h18, MODE_PLAIN, 5'h0, 8'h15));
    regchk("disp load", 5'h18, 8'h33);
    regchk("z kept", 5'h1e, 8'h30);
    rd_chk("mem flags", OFS_STAT, 32'ha5);
    wr(OFS_CMD, cmd(REGISTER_PAIR_COPY_OP, PTR_X, 5'h18, MODE_PLAIN, 5'h1a, 8'h0));
    regchk("pair low", 5'h18, 8'h40);
    regchk("pair high", 5'h19, 8'h00);
    rd_chk("no error", OFS_INFO, 32'h0);
    $display("memory test done");
    // rejected op, unmapped read, masked lanes
    wr(OFS_CMD, cmd(DISPLACED_LOAD_OP, PTR_X, 5'h18, MODE_PLAIN, 5'h0, 8'h0));
    rd_chk("error", OFS_INFO, 32'h1);
    rd_chk("unmapped", 5'h18, 32'h0);
    lanes = 4'h0;
    wr(OFS_STAT, 32'hff);
    lanes = 4'hf;
    rd_chk("lanes", OFS_STAT, 32'ha5);
    // reset again in mid run
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk("stat again", OFS_STAT, 32'h0);
    $display("misc test done");
    conclude();
  end
endmodule
`default_nettype wire
